// ### hw/cts_pkg.sv
// Constants and types for the clock trim and oscillator status block
`default_nettype none
package cts_pkg;
  localparam int          ADDR_W      = 12;
  localparam logic [11:0] OFF_TRIM    = 12'h000;
  localparam logic [11:0] OFF_STAT    = 12'h004;
  localparam logic [11:0] OFF_TUNE    = 12'h008;
  localparam logic [11:0] OFF_REFCTL  = 12'h00C;
  localparam logic [11:0] OFF_UNLOCK  = 12'h010;

  localparam int TRIM_LSB   = 23;
  localparam int TRIM_W     = 9;
  localparam int DIV_LSB    = 16;
  localparam int DIV_W      = 15;
  localparam int CTL_ON     = 15;
  localparam int CTL_DIVSW  = 9;
  localparam int CTL_ACTIVE = 8;
  localparam int TUNE_W     = 6;
  localparam int UNL_OPEN   = 0;

  // Index of each ready flag in the raw input vector
  localparam int NRDY     = 6;
  localparam int RDY_FRC  = 0;
  localparam int RDY_PDIV = 1;
  localparam int RDY_PRIMARY_OSC = 2;
  localparam int RDY_SECONDARY_OSC = 3;
  localparam int RDY_LOW_POWER_RC_OSC = 4;
  localparam int RDY_PLL  = 5;

  // Bit of each ready flag in the status word
  localparam int ST_FRC  = 0;
  localparam int ST_PDIV = 1;
  localparam int ST_PRIMARY_OSC = 2;
  localparam int ST_SECONDARY_OSC = 4;
  localparam int ST_LOW_POWER_RC_OSC = 5;
  localparam int ST_PLL  = 7;

  localparam logic [TRIM_W-1:0] TRIM_RST  = 9'h000;
  localparam logic [DIV_W-1:0]  DIV_RST   = 15'h0000;
  localparam logic [TUNE_W-1:0] TUNE_RST  = 6'h00;
  localparam logic [31:0]       WORD_ZERO = 32'h0000_0000;
  localparam logic [DIV_W:0]    CNT_ONE   = 16'h0001;
  localparam logic [3:0]        STRB_ALL  = 4'hF;

  // Unlock keys: arbitrary values
  localparam logic [31:0] UNLOCK_KEY_A = 32'h1234_ABCD;
  localparam logic [31:0] UNLOCK_KEY_B = 32'hEDCB_4321;

  typedef enum logic [2:0] {
    UL_IDLE = 3'b001,
    UL_KEY1 = 3'b010,
    UL_OPEN = 3'b100
  } cts_unlock_e;
endpackage
`default_nettype wire

// ### hw/cts_ref_if.sv
// Signals between the register block and the reference divider
`default_nettype none
interface cts_ref_if;
  import cts_pkg::*;
  logic              enable;
  logic [DIV_W-1:0]  int_div;
  logic [TRIM_W-1:0] frac;
  logic              src_tick;
  logic              ref_out;
  logic              active;
  modport gen (input enable, input int_div, input frac, input src_tick,
               output ref_out, output active);
  modport ctl (output enable, output int_div, output frac, output src_tick,
               input ref_out, input active);
endinterface
`default_nettype wire

// ### hw/cts_ref_divider.sv
// Fractional reference clock divider fed by source ticks
`default_nettype none
module cts_ref_divider
  import cts_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  cts_ref_if.gen    ref_if
);
  logic [DIV_W:0]    half_cnt;
  logic [DIV_W:0]    half_len;
  logic [TRIM_W-1:0] frac_acc;
  logic [TRIM_W:0]   acc_sum;
  logic              extra_tick;
  logic              half_end;
  logic              no_div;
  logic              out_q;
  logic              active_q;

  assign no_div   = ref_if.int_div == DIV_RST;
  // Half period is int_div ticks, stretched by one on fraction carry
  assign half_len = {1'b0, ref_if.int_div} + {{DIV_W{1'b0}}, extra_tick};
  assign acc_sum  = {1'b0, frac_acc} + {1'b0, ref_if.frac};
  assign half_end = ref_if.src_tick &&
                    (no_div || half_cnt == half_len - CNT_ONE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_cnt <= '0;
    end else if (!ref_if.enable || half_end) begin
      half_cnt <= '0;
    end else if (ref_if.src_tick) begin
      half_cnt <= half_cnt + CNT_ONE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frac_acc   <= TRIM_RST;
      extra_tick <= 1'b0;
    end else if (!ref_if.enable || no_div) begin
      frac_acc   <= TRIM_RST; // Fraction ignored without division
      extra_tick <= 1'b0;
    end else if (half_end) begin
      frac_acc   <= acc_sum[TRIM_W-1:0]; // Adds frac/512 on average
      extra_tick <= acc_sum[TRIM_W];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q <= 1'b0;
    end else if (!ref_if.enable) begin
      out_q <= 1'b0; // Generator stopped while disabled
    end else if (half_end) begin
      out_q <= ~out_q; // Zero divider toggles on every tick
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_q <= 1'b0;
    end else begin
      active_q <= ref_if.enable;
    end
  end

  assign ref_if.ref_out = out_q;
  assign ref_if.active  = active_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_off_quiet;
    !ref_if.enable |=> !ref_if.ref_out && !ref_if.active;
  endproperty
  a_off_quiet: assert property (p_off_quiet)
    else $error("Reference output runs while disabled");

  property p_nodiv_toggle;
    ref_if.enable && no_div && ref_if.src_tick
      |=> ref_if.ref_out != $past(ref_if.ref_out);
  endproperty
  a_nodiv_toggle: assert property (p_nodiv_toggle)
    else $error("Undivided output missed a source tick");

  property p_nodiv_no_frac;
    ref_if.enable && no_div |=> !extra_tick && frac_acc == TRIM_RST;
  endproperty
  a_nodiv_no_frac: assert property (p_nodiv_no_frac)
    else $error("Fraction applied with zero divider");

  property p_zero_trim;
    ref_if.enable && ref_if.frac == TRIM_RST && !extra_tick |=> !extra_tick;
  endproperty
  a_zero_trim: assert property (p_zero_trim)
    else $error("Zero trim stretched a half period");
endmodule
`default_nettype wire

// ### hw/cts_clock_trim_and_status.sv
// Clock trim, oscillator ready status and fast RC tuning on APB
//
// Local design decisions: the register offsets and the APB slave port.
`default_nettype none
// Contract
// - Trim field bits 31:23; value N adds N/512 to divider.
// - While enabled, trim waits for divider switch request before use.
// - Trim ignored entirely while integer divider is zero.
// - Trim bits 22:0 read zero; trim resets to zero.
// - Status bit 7 follows PLL lock.
// - Status bit 5 follows low-power RC stable.
// - Status bit 4 follows secondary oscillator stable.
// - Status bit 2 follows primary oscillator stable.
// - Status bit 1 follows postscaled PLL clock stable.
// - Status bit 0 follows fast RC stable.
// - Other status bits read zero; status read-only, resets zero.
// - Six-bit signed tuning code in bits 5:0 drives the oscillator.
// - Tuning writes accepted only after the unlock sequence.
// - Tuning bits 31:6 read zero; tuning resets to zero.
// - Switch request reads one until hardware finishes the switch.
// - Enable bit turns the reference generator on and off.
// - Integer divider zero means no division.
module cts_clock_trim_and_status
  import cts_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              pll_locked,
  input  wire logic              low_power_rc_osc_stable,
  input  wire logic              secondary_osc_stable,
  input  wire logic              primary_osc_stable,
  input  wire logic              pll_div_stable,
  input  wire logic              frc_stable,
  input  wire logic              ref_src_tick,
  output logic                   ref_clk_out,
  output logic [TUNE_W-1:0]      freq_trim_code
);
  logic              setup_ph;
  logic              access_ph;
  logic              wr_take;
  logic [31:0]       rd_mux;
  logic [31:0]       wr_image;
  logic [TRIM_W-1:0] trim_field;
  logic [TRIM_W-1:0] trim_applied;
  logic [DIV_W-1:0]  div_field;
  logic [DIV_W-1:0]  div_applied;
  logic              ref_on;
  logic              div_sw;
  logic              next_div_sw;
  logic [TUNE_W-1:0] tune;
  cts_unlock_e       unl_state;
  cts_unlock_e       next_unl_state;
  logic [NRDY-1:0]   rdy_raw;
  logic [NRDY-1:0]   sync_a;
  logic [NRDY-1:0]   sync_b;
  logic [NRDY-1:0]   sync_c;
  logic [NRDY-1:0]   rdy;

  cts_ref_if ref_if ();

  function automatic logic addr_known(input logic [ADDR_W-1:0] a);
    return a == OFF_TRIM || a == OFF_STAT || a == OFF_TUNE ||
           a == OFF_REFCTL || a == OFF_UNLOCK;
  endfunction

  function automatic logic [31:0] merge_bytes(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] status_image(input logic [NRDY-1:0] r);
    logic [31:0] img;
    img          = WORD_ZERO; // Unused status bits stay zero
    img[ST_FRC]  = r[RDY_FRC];
    img[ST_PDIV] = r[RDY_PDIV];
    img[ST_PRIMARY_OSC] = r[RDY_PRIMARY_OSC];
    img[ST_SECONDARY_OSC] = r[RDY_SECONDARY_OSC];
    img[ST_LOW_POWER_RC_OSC] = r[RDY_LOW_POWER_RC_OSC];
    img[ST_PLL]  = r[RDY_PLL];
    return img;
  endfunction

  function automatic logic key_match(input logic [31:0] key,
                                     input logic [31:0] wd,
                                     input logic [3:0]  be);
    return be == STRB_ALL && wd == key;
  endfunction

  // APB slave: zero wait states, read data captured in the setup phase
  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable;
  assign wr_take   = access_ph && pwrite;
  assign pready    = 1'b1;

  always_comb begin
    rd_mux = WORD_ZERO;
    case (paddr)
      OFF_TRIM: begin
        rd_mux[TRIM_LSB +: TRIM_W] = trim_field; // Low bits zero
      end
      OFF_STAT: begin
        rd_mux = status_image(rdy);
      end
      OFF_TUNE: begin
        rd_mux[TUNE_W-1:0] = tune; // Upper bits zero
      end
      OFF_REFCTL: begin
        rd_mux[DIV_LSB +: DIV_W] = div_field;
        rd_mux[CTL_ON]           = ref_on;
        rd_mux[CTL_DIVSW]        = div_sw;
        rd_mux[CTL_ACTIVE]       = ref_if.active;
      end
      OFF_UNLOCK: begin
        rd_mux[UNL_OPEN] = unl_state == UL_OPEN;
      end
      default: begin
        rd_mux = WORD_ZERO;
      end
    endcase
  end

  assign wr_image = merge_bytes(rd_mux, pwdata, pstrb);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= WORD_ZERO;
      pslverr <= 1'b0;
    end else if (setup_ph) begin
      prdata  <= pwrite ? WORD_ZERO : rd_mux;
      pslverr <= !addr_known(paddr);
    end
  end

  // Trim: software copy and the value the divider actually uses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim_field <= TRIM_RST;
    end else if (wr_take && paddr == OFF_TRIM) begin
      trim_field <= wr_image[TRIM_LSB +: TRIM_W];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_on    <= 1'b0;
      div_field <= DIV_RST;
    end else if (wr_take && paddr == OFF_REFCTL) begin
      ref_on    <= wr_image[CTL_ON];
      div_field <= wr_image[DIV_LSB +: DIV_W];
    end
  end

  // A software set of the switch request wins over the hardware clear
  always_comb begin
    next_div_sw = div_sw;
    if (wr_take && paddr == OFF_REFCTL && wr_image[CTL_DIVSW]) begin
      next_div_sw = 1'b1;
    end else if (div_sw) begin
      next_div_sw = 1'b0; // Switch finishes one cycle after request
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_sw <= 1'b0;
    end else begin
      div_sw <= next_div_sw;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim_applied <= TRIM_RST;
      div_applied  <= DIV_RST;
    end else if (!ref_on || div_sw) begin
      trim_applied <= trim_field; // Held pending while enabled
      div_applied  <= div_field;
    end
  end

  assign ref_if.enable   = ref_on;
  assign ref_if.int_div  = div_applied;
  assign ref_if.frac     = trim_applied;
  assign ref_if.src_tick = ref_src_tick;
  assign ref_clk_out     = ref_if.ref_out;

  cts_ref_divider u_ref_divider (
    .pclk    (pclk),
    .presetn (presetn),
    .ref_if  (ref_if.gen)
  );

  // Unlock sequence: key A then key B opens one tuning write
  always_comb begin
    next_unl_state = unl_state;
    if (wr_take && paddr == OFF_UNLOCK) begin
      case (unl_state)
        UL_IDLE: begin
          next_unl_state = key_match(UNLOCK_KEY_A, pwdata, pstrb) ?
                           UL_KEY1 : UL_IDLE;
        end
        UL_KEY1: begin
          next_unl_state = key_match(UNLOCK_KEY_B, pwdata, pstrb) ?
                           UL_OPEN : UL_IDLE;
        end
        UL_OPEN: begin
          next_unl_state = key_match(UNLOCK_KEY_A, pwdata, pstrb) ?
                           UL_KEY1 : UL_IDLE;
        end
        default: begin
          next_unl_state = UL_IDLE;
        end
      endcase
    end else if (wr_take && paddr == OFF_TUNE) begin
      next_unl_state = UL_IDLE; // Each tuning write uses up the unlock
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unl_state <= UL_IDLE;
    end else begin
      unl_state <= next_unl_state;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tune <= TUNE_RST;
    end else if (wr_take && paddr == OFF_TUNE && unl_state == UL_OPEN) begin
      tune <= wr_image[TUNE_W-1:0];
    end
  end

  // Two's complement code: zero is nominal, 011111 top, 100000 bottom
  assign freq_trim_code = tune;

  // Ready flags: three stages, a change counts once stages two and three agree
  assign rdy_raw[RDY_FRC]  = frc_stable;
  assign rdy_raw[RDY_PDIV] = pll_div_stable;
  assign rdy_raw[RDY_PRIMARY_OSC] = primary_osc_stable;
  assign rdy_raw[RDY_SECONDARY_OSC] = secondary_osc_stable;
  assign rdy_raw[RDY_LOW_POWER_RC_OSC] = low_power_rc_osc_stable;
  assign rdy_raw[RDY_PLL]  = pll_locked;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= '0;
      sync_b <= '0;
      sync_c <= '0;
    end else begin
      sync_a <= rdy_raw;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy <= '0;
    end else begin
      for (int i = 0; i < NRDY; i++) begin
        if (sync_b[i] == sync_c[i]) begin
          rdy[i] <= sync_c[i]; // Set and cleared by hardware
        end
      end
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_read(logic [ADDR_W-1:0] a);
    psel && !penable && !pwrite && paddr == a;
  endsequence

  sequence s_write(logic [ADDR_W-1:0] a);
    psel && penable && pwrite && paddr == a && pstrb == STRB_ALL;
  endsequence

  property p_trim_low_zero;
    s_read(OFF_TRIM) |=> prdata[TRIM_LSB-1:0] == '0;
  endproperty
  a_trim_low_zero: assert property (p_trim_low_zero)
    else $error("Trim low bits not zero");

  property p_trim_write;
    s_write(OFF_TRIM) |=> trim_field == $past(pwdata[TRIM_LSB +: TRIM_W]);
  endproperty
  a_trim_write: assert property (p_trim_write)
    else $error("Trim write not stored");

  property p_trim_pending;
    ref_on && !div_sw |=> trim_applied == $past(trim_applied);
  endproperty
  a_trim_pending: assert property (p_trim_pending)
    else $error("Trim applied without switch request");

  property p_switch_done;
    div_sw && !(wr_take && paddr == OFF_REFCTL)
      |=> !div_sw && trim_applied == $past(trim_field);
  endproperty
  a_switch_done: assert property (p_switch_done)
    else $error("Divider switch did not complete");

  property p_status_reserved;
    s_read(OFF_STAT) |=> prdata[31:8] == '0 && !prdata[6] && !prdata[3];
  endproperty
  a_status_reserved: assert property (p_status_reserved)
    else $error("Reserved status bits not zero");

  property p_tune_locked;
    wr_take && paddr == OFF_TUNE && unl_state != UL_OPEN |=> $stable(tune);
  endproperty
  a_tune_locked: assert property (p_tune_locked)
    else $error("Tuning changed without unlock");

  property p_tune_write;
    s_write(OFF_TUNE) ##0 unl_state == UL_OPEN
      |=> freq_trim_code == $past(pwdata[TUNE_W-1:0]) &&
          unl_state == UL_IDLE;
  endproperty
  a_tune_write: assert property (p_tune_write)
    else $error("Unlocked tuning write not applied");

  property p_tune_high_zero;
    s_read(OFF_TUNE) |=> prdata[31:TUNE_W] == '0;
  endproperty
  a_tune_high_zero: assert property (p_tune_high_zero)
    else $error("Tuning upper bits not zero");

  for (genvar g = 0; g < NRDY; g++) begin : g_rdy_chk
    property p_ready_rise;
      rdy_raw[g] [*4] |=> rdy[g];
    endproperty
    a_ready_rise: assert property (p_ready_rise)
      else $error("Ready flag did not follow a steady high");

    property p_ready_fall;
      !rdy_raw[g] [*4] |=> !rdy[g];
    endproperty
    a_ready_fall: assert property (p_ready_fall)
      else $error("Ready flag did not follow a steady low");
  end
endmodule
`default_nettype wire

// ### bench/tb.sv
// Self-checking bench for the clock trim and oscillator status block
`default_nettype none
module tb
  import cts_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata;
  logic [3:0]        pstrb;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic [NRDY-1:0]   rdy_in;
  logic              ref_src_tick;
  logic              ref_clk_out;
  logic [TUNE_W-1:0] freq_trim_code;
  logic [31:0]       rd;
  logic              rd_err;
  logic [3:0]        strb_sel;
  int                err_total;
  int                n_tests;
  int                cycles;
  int                st_bit [NRDY];

  cts_clock_trim_and_status dut (
    .pclk           (pclk),
    .presetn        (presetn),
    .psel           (psel),
    .penable        (penable),
    .pwrite         (pwrite),
    .paddr          (paddr),
    .pwdata         (pwdata),
    .pstrb          (pstrb),
    .prdata         (prdata),
    .pready         (pready),
    .pslverr        (pslverr),
    .pll_locked     (rdy_in[RDY_PLL]),
    .low_power_rc_osc_stable    (rdy_in[RDY_LOW_POWER_RC_OSC]),
    .secondary_osc_stable    (rdy_in[RDY_SECONDARY_OSC]),
    .primary_osc_stable    (rdy_in[RDY_PRIMARY_OSC]),
    .pll_div_stable (rdy_in[RDY_PDIV]),
    .frc_stable     (rdy_in[RDY_FRC]),
    .ref_src_tick   (ref_src_tick),
    .ref_clk_out    (ref_clk_out),
    .freq_trim_code (freq_trim_code)
  );

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      complete_run();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; entered just after an edge, leaves one idle cycle
  task automatic apb_xfer(input logic wr, input logic [ADDR_W-1:0] a,
                          input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= strb_sel;
    @(posedge pclk);
    penable <= 1'b1;
    // Ends once pready reads one; only the bench timeout ends a stalled wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd      = prdata;
    rd_err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd_chk(input string nm, input logic [ADDR_W-1:0] a,
                        input logic [31:0] exp);
    apb_xfer(1'b0, a, WORD_ZERO);
    chk(nm, rd, exp);
  endtask

  task automatic unlock();
    apb_xfer(1'b1, OFF_UNLOCK, UNLOCK_KEY_A);
    apb_xfer(1'b1, OFF_UNLOCK, UNLOCK_KEY_B);
  endtask

  function automatic logic [31:0] ctl_w(input int dv, input bit en,
                                        input bit sw, input bit act);
    ctl_w = (32'(dv) << DIV_LSB) | (32'(en) << CTL_ON) |
            (32'(sw) << CTL_DIVSW) | (32'(act) << CTL_ACTIVE);
  endfunction

  // Ticks spanned by four output half periods after the first toggle
  task automatic gen_span(input string nm, input int exp_span);
    int   nt;
    int   t0;
    int   span;
    logic prev;
    nt   = 0;
    t0   = 0;
    span = 0;
    prev = ref_clk_out;
    for (int tk = 1; tk <= 40 && nt < 5; tk++) begin
      ref_src_tick <= 1'b1;
      @(posedge pclk);
      ref_src_tick <= 1'b0;
      repeat (3) @(posedge pclk);
      if (ref_clk_out !== prev) begin
        nt++;
        prev = ref_clk_out;
        if (nt == 1) t0 = tk;
        if (nt == 5) span = tk - t0;
      end
    end
    chk(nm, 32'(span), 32'(exp_span));
  endtask

  initial begin
    err_total    = 0;
    n_tests      = 0;
    cycles       = 0;
    presetn      = 1'b0;
    psel         = 1'b0;
    penable      = 1'b0;
    pwrite       = 1'b0;
    paddr        = '0;
    pwdata       = WORD_ZERO;
    pstrb        = 4'h0;
    strb_sel     = STRB_ALL;
    rdy_in       = '0;
    ref_src_tick = 1'b0;
    st_bit[RDY_FRC]  = ST_FRC;
    st_bit[RDY_PDIV] = ST_PDIV;
    st_bit[RDY_PRIMARY_OSC] = ST_PRIMARY_OSC;
    st_bit[RDY_SECONDARY_OSC] = ST_SECONDARY_OSC;
    st_bit[RDY_LOW_POWER_RC_OSC] = ST_LOW_POWER_RC_OSC;
    st_bit[RDY_PLL]  = ST_PLL;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);

    rd_chk("trim reset", OFF_TRIM, WORD_ZERO);
    rd_chk("status reset", OFF_STAT, WORD_ZERO);
    rd_chk("tune reset", OFF_TUNE, WORD_ZERO);
    chk("tune code reset", 32'(freq_trim_code), WORD_ZERO);

    // Trim field only, low bits unimplemented
    apb_xfer(1'b1, OFF_TRIM, 32'hFFFF_FFFF);
    rd_chk("trim field", OFF_TRIM, 32'hFF80_0000);
    // Top byte only: bit 23 keeps its old value
    strb_sel = 4'h8;
    apb_xfer(1'b1, OFF_TRIM, 32'h1200_00FF);
    strb_sel = STRB_ALL;
    rd_chk("trim byte", OFF_TRIM, 32'h1280_0000);
    apb_xfer(1'b1, OFF_STAT, 32'hFFFF_FFFF);
    rd_chk("status ro", OFF_STAT, WORD_ZERO);
    apb_xfer(1'b0, 12'h0FC, WORD_ZERO);
    chk("unmapped err", 32'(rd_err), 32'h0000_0001);
    chk("unmapped data", rd, WORD_ZERO);
    chk("ready", 32'(pready), 32'h0000_0001);

    // Each ready flag: invisible at once, visible after synchronising
    for (int i = 0; i < NRDY; i++) begin
      rdy_in <= NRDY'(1) << i;
      rd_chk("flag early", OFF_STAT, WORD_ZERO);
      repeat (6) @(posedge pclk);
      rd_chk("flag set", OFF_STAT, 32'h1 << st_bit[i]);
      // Let the flag clear before the next one is raised
      rdy_in <= '0;
      repeat (6) @(posedge pclk);
    end
    rdy_in <= '1;
    repeat (6) @(posedge pclk);
    rd_chk("all flags", OFF_STAT, 32'h0000_00B7);
    rdy_in <= '0;
    repeat (6) @(posedge pclk);
    rd_chk("flags clear", OFF_STAT, WORD_ZERO);

    // Tuning write protection and signed code
    apb_xfer(1'b1, OFF_TUNE, 32'h0000_003F);
    rd_chk("tune locked", OFF_TUNE, WORD_ZERO);
    unlock();
    rd_chk("unlock open", OFF_UNLOCK, 32'h0000_0001);
    apb_xfer(1'b1, OFF_TUNE, 32'hFFFF_FFDF);
    rd_chk("tune plus", OFF_TUNE, 32'h0000_001F);
    chk("code plus", 32'(freq_trim_code), 32'h0000_001F);
    apb_xfer(1'b1, OFF_TUNE, 32'h0000_0020);
    rd_chk("tune relocked", OFF_TUNE, 32'h0000_001F);
    unlock();
    apb_xfer(1'b1, OFF_TUNE, 32'h0000_0020);
    chk("code minus", 32'(freq_trim_code), 32'h0000_0020);
    unlock();
    apb_xfer(1'b1, OFF_TUNE, WORD_ZERO);
    chk("code nominal", 32'(freq_trim_code), WORD_ZERO);

    // Fractional divider: half trim on divider two
    apb_xfer(1'b1, OFF_TRIM, 32'(256) << TRIM_LSB);
    apb_xfer(1'b1, OFF_REFCTL, ctl_w(2, 0, 0, 0));
    apb_xfer(1'b1, OFF_REFCTL, ctl_w(2, 1, 0, 0));
    repeat (2) @(posedge pclk);
    gen_span("span half trim", 10);
    apb_xfer(1'b1, OFF_TRIM, WORD_ZERO); // Zero trim held pending while enabled
    gen_span("span pending", 10);
    apb_xfer(1'b1, OFF_REFCTL, ctl_w(2, 1, 1, 0));
    rd_chk("switch done", OFF_REFCTL, ctl_w(2, 1, 0, 1));
    gen_span("span no trim", 8);
    apb_xfer(1'b1, OFF_TRIM, 32'(511) << TRIM_LSB);
    apb_xfer(1'b1, OFF_REFCTL, ctl_w(0, 1, 1, 0));
    gen_span("span no divide", 4);

    // Disabled generator stays low
    apb_xfer(1'b1, OFF_REFCTL, WORD_ZERO);
    repeat (3) @(posedge pclk);
    for (int k = 0; k < 4; k++) begin
      ref_src_tick <= 1'b1;
      @(posedge pclk);
      ref_src_tick <= 1'b0;
      repeat (2) @(posedge pclk);
      chk("ref off", 32'(ref_clk_out), WORD_ZERO);
    end
    complete_run();
  end
endmodule
`default_nettype wire
